// File: src/rxs_pkg.sv
// rxs_pkg: constants shared by the receive status and control block
package rxs_pkg;
  // register byte addresses on the avalon slave
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h04;
  localparam logic [4:0] ADDR_SFIFO = 5'h08;
  localparam logic [4:0] ADDR_DFIFO = 5'h0C;
  localparam logic [4:0] ADDR_INFO = 5'h10;
  // mac_control_register fields
  localparam int CTRL_RX_EN_BIT = 2;
  localparam int CTRL_PASS_BAD_BIT = 16;
  // status register fields
  localparam int STAT_RX_ON_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_HALTED_BIT = 2;
  // receive status word fields
  localparam int SW_LEN_LO = 16;
  localparam int SW_ERR_SUM = 15;
  localparam int SW_RUNT = 11;
  localparam int SW_MCAST = 10;
  localparam int SW_LONG = 7;
  localparam int SW_LATE = 6;
  localparam int SW_FTYPE = 5;
  localparam int SW_WDOG = 4;
  localparam int SW_MIIERR = 3;
  localparam int SW_DRIB = 2;
  localparam int SW_CRC = 1;
  // frame length limits and header offsets in bytes, and the type field threshold
  localparam logic [13:0] COLL_WIN_BYTES = 14'h0040;
  localparam logic [13:0] MAX_FRAME_BYTES = 14'h05EE;
  localparam logic [13:0] WDOG_BYTES = 14'h0800;
  localparam logic [13:0] HDR_BYTES = 14'h000E;
  localparam logic [13:0] LT_HI_IDX = 14'h000C;
  localparam logic [15:0] ETH_TYPE_MIN = 16'h05DC;
  // mii preamble and start nibbles
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [3:0] SFD_NIB = 4'hD;
  // crc32, reflected form, and the register value after a good fcs
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
  // receive state, gray along idle-preamble-data-drop
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_DATA = 2'b11,
    ST_DROP = 2'b10
  } rxs_state_type;
endpackage

// File: src/rxs_crc_byte.sv
// rxs_crc_byte: one byte step of the reflected ethernet crc32
module rxs_crc_byte (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  // bit-serial form unrolled by the loop, lsb of the byte first
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      c = (c >> 1) ^ (rxs_pkg::CRC_POLY & {32{c[0] ^ data[i]}});
    end
    crc_out = c;
  end
endmodule

// File: src/rxs_rx_status.sv
// rxs_rx_status: mii receive classification, status/data fifos, receiver stop and error flag
// Summary of operation
// - runt below 64 bytes, pass only if enabled
// - multicast destination sets bit 10
// - bits 9:8 and 0 always zero
// - over 1518 bytes flags bit 7, no truncation
// - collision after window sets bit 6
// - type field above 1500 sets bit 5
// - no frame type under 14 bytes
// - watchdog past 2048 bytes sets bit 4
// - mii receive error sets bit 3
// - odd nibble ending sets dribbling bit 2
// - no dribbling bit with late collision
// - dribble without crc error is valid frame
// - bad fcs or mii error sets bit 1
// - crc bit meaningless for runt, late, watchdog
// - one halted pulse after receiver stops
// - error flag never stops the receiver
// - fifo underruns and status overrun raise error
// - bit 15 is or of 11,7,6,1
// - bits 29:16 hold frame byte count
// - status word pushed after frame data
module rxs_rx_status #(
  parameter int DFIFO_AW = 9,
  parameter int SFIFO_AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mii_rx_dv,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_er,
  input wire logic mii_col,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic receiver_halted_interrupt,
  output logic receive_error_flag
);
  localparam int DDEPTH = 1 << DFIFO_AW;
  localparam int SDEPTH = 1 << SFIFO_AW;

  rxs_pkg::rxs_state_type state_q, state_d;
  logic [3:0] nib_q, nib_d;
  logic half_q, half_d;
  logic [13:0] cnt_q, cnt_d;
  logic [31:0] crc_q, crc_d, crc_next;
  logic [31:0] word_q, word_d;
  logic [1:0] lane_q, lane_d;
  logic [7:0] lt_hi_q, lt_hi_d;
  logic mcast_q, mcast_d, ftype_q, ftype_d, late_q, late_d;
  logic wdog_q, wdog_d, mii_q, mii_d, ovf_q, ovf_d;
  logic [DFIFO_AW:0] dwr_q, dwr_d, dcommit_q, dcommit_d, drd_q, drd_d;
  logic [SFIFO_AW:0] swr_q, swr_d, srd_q, srd_d;
  logic pend_q, pend_d;
  logic [31:0] sword_q, sword_d;
  logic rx_on_q, rx_on_d, halt_q, halt_d, halted_q, halted_d;
  logic rx_en_q, rx_en_d, pass_bad_q, pass_bad_d, err_q, err_d;
  logic wait_q, wait_d, rd_ok_q, rd_ok_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] dmem [DDEPTH];
  logic [31:0] smem [SDEPTH];
  logic [7:0] rx_byte;
  logic byte_en, dpush, spush, end_frame;
  logic [31:0] dpush_data, end_word;
  logic [DFIFO_AW:0] dused;
  logic [SFIFO_AW:0] sused;
  logic runt, crc_err, late_now, accept;

  rxs_crc_byte u_crc (
    .crc_in(crc_q),
    .data(rx_byte),
    .crc_out(crc_next)
  );

  assign dused = dcommit_q - drd_q;
  assign sused = swr_q - srd_q;
  assign rx_byte = {mii_rxd, nib_q};
  assign accept = (avs_read || avs_write) && !wait_q;

  // receive path: nibble pairing, frame classification and data pushes
  always_comb begin
    state_d = state_q;
    nib_d = nib_q;
    half_d = half_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    word_d = word_q;
    lane_d = lane_q;
    lt_hi_d = lt_hi_q;
    mcast_d = mcast_q;
    ftype_d = ftype_q;
    late_d = late_q;
    wdog_d = wdog_q;
    mii_d = mii_q;
    ovf_d = ovf_q;
    dwr_d = dwr_q;
    dcommit_d = dcommit_q;
    pend_d = 1'b0;
    sword_d = sword_q;
    byte_en = 1'b0;
    dpush = 1'b0;
    dpush_data = word_q;
    end_frame = 1'b0;
    end_word = word_q;
    late_now = mii_col && (cnt_q >= rxs_pkg::COLL_WIN_BYTES);
    runt = cnt_q < rxs_pkg::COLL_WIN_BYTES;
    crc_err = (crc_q != rxs_pkg::CRC_RESIDUE) || mii_q;
    case (state_q)
      rxs_pkg::ST_IDLE: begin
        // a frame that starts while stopped is skipped whole
        if (mii_rx_dv) begin
          state_d = rx_on_q ? rxs_pkg::ST_PRE : rxs_pkg::ST_DROP;
        end
      end
      rxs_pkg::ST_PRE: begin
        cnt_d = '0;
        crc_d = rxs_pkg::CRC_INIT;
        half_d = 1'b0;
        lane_d = '0;
        {mcast_d, ftype_d, late_d, wdog_d, mii_d, ovf_d} = '0;
        if (!mii_rx_dv) begin
          state_d = rxs_pkg::ST_IDLE;
        end else if (mii_rxd == rxs_pkg::SFD_NIB) begin
          state_d = rxs_pkg::ST_DATA;
        end else if (mii_rxd != rxs_pkg::PRE_NIB) begin
          state_d = rxs_pkg::ST_DROP;
        end
      end
      rxs_pkg::ST_DATA: begin
        if (mii_rx_dv) begin
          if (mii_rx_er) begin
            mii_d = 1'b1;
          end
          if (late_now) begin
            late_d = 1'b1;
          end
          half_d = !half_q;
          nib_d = mii_rxd;
          // bytes past the watchdog limit are neither counted nor stored
          byte_en = half_q && !wdog_q;
          if (byte_en && cnt_q == rxs_pkg::WDOG_BYTES) begin
            wdog_d = 1'b1;
            byte_en = 1'b0;
          end
          if (byte_en) begin
            cnt_d = cnt_q + 14'd1;
            crc_d = crc_next;
            if (cnt_q == '0) begin
              mcast_d = rx_byte[0];
            end
            if (cnt_q == rxs_pkg::LT_HI_IDX) begin
              lt_hi_d = rx_byte;
            end
            if (cnt_q == rxs_pkg::LT_HI_IDX + 14'd1) begin
              ftype_d = {lt_hi_q, rx_byte} > rxs_pkg::ETH_TYPE_MIN;
            end
            word_d[lane_q*8 +: 8] = rx_byte;
            lane_d = lane_q + 2'd1;
            if (lane_q == 2'd3) begin
              dpush = 1'b1;
              dpush_data = word_d;
              word_d = '0;
            end
          end
        end else begin
          // end of frame: flush the partial word, status follows next cycle
          end_frame = 1'b1;
          state_d = rxs_pkg::ST_IDLE;
          if (lane_q != 2'd0) begin
            dpush = 1'b1;
            dpush_data = word_q;
          end
          word_d = '0;
          pend_d = 1'b1;
          sword_d = '0;
          sword_d[rxs_pkg::SW_LEN_LO +: 14] = cnt_q;
          sword_d[rxs_pkg::SW_RUNT] = runt;
          sword_d[rxs_pkg::SW_MCAST] = mcast_q;
          sword_d[rxs_pkg::SW_LONG] = cnt_q > rxs_pkg::MAX_FRAME_BYTES;
          sword_d[rxs_pkg::SW_LATE] = late_q;
          sword_d[rxs_pkg::SW_FTYPE] = ftype_q && (cnt_q >= rxs_pkg::HDR_BYTES);
          sword_d[rxs_pkg::SW_WDOG] = wdog_q;
          sword_d[rxs_pkg::SW_MIIERR] = mii_q;
          // nibble granularity: a leftover nibble is four dribbling bits
          sword_d[rxs_pkg::SW_DRIB] = half_q && !late_q;
          // crc bit still reported for runt, late and watchdog frames, host ignores it there
          sword_d[rxs_pkg::SW_CRC] = crc_err;
          sword_d[rxs_pkg::SW_ERR_SUM] = runt || sword_d[rxs_pkg::SW_LONG] || late_q || crc_err;
          // drop runts unless passing bad frames; a full data fifo also drops
          if ((runt && !pass_bad_q) || ovf_q) begin
            pend_d = 1'b0;
          end
        end
      end
      rxs_pkg::ST_DROP: begin
        if (!mii_rx_dv) begin
          state_d = rxs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = rxs_pkg::ST_IDLE;
      end
    endcase
    // speculative write pointer: a dropped frame rewinds to the committed one
    if (dpush) begin
      if ((dwr_q - drd_q) == (DFIFO_AW + 1)'(DDEPTH) || ovf_q) begin
        ovf_d = 1'b1;
        dpush = 1'b0;
      end else begin
        dwr_d = dwr_q + 1'b1;
      end
    end
    if (end_frame && !pend_d) begin
      dwr_d = dcommit_q;
    end
    spush = 1'b0;
    if (pend_q) begin
      if (sused == (SFIFO_AW + 1)'(SDEPTH)) begin
        dwr_d = dcommit_q; // status overrun drops the frame
      end else begin
        spush = 1'b1;
        dcommit_d = dwr_q;
      end
    end
  end

  // data and status fifo storage
  always_ff @(posedge clk) begin
    if (dpush) begin
      dmem[dwr_q[DFIFO_AW-1:0]] <= dpush_data;
    end
    if (spush) begin
      smem[swr_q[SFIFO_AW-1:0]] <= sword_q;
    end
  end

  // host side: registers, fifo pops, stop/start and the error flag
  always_comb begin
    rx_en_d = rx_en_q;
    pass_bad_d = pass_bad_q;
    err_d = err_q;
    halted_d = halted_q;
    rx_on_d = rx_on_q;
    halt_d = 1'b0;
    drd_d = drd_q;
    srd_d = srd_q;
    swr_d = swr_q + (SFIFO_AW + 1)'(spush);
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    rd_ok_d = rd_ok_q;
    // receiver stops only while idle or dropping a frame, then pulses once
    if (!rx_en_q && rx_on_q && (state_q == rxs_pkg::ST_IDLE || state_q == rxs_pkg::ST_DROP)) begin
      rx_on_d = 1'b0;
      halt_d = 1'b1;
      halted_d = 1'b1;
    end else if (rx_en_q && !rx_on_q) begin
      rx_on_d = 1'b1;
    end
    if (pend_q && !spush) begin
      err_d = 1'b1;
    end
    // read data is sampled in the waiting cycle and handed over at accept
    if (avs_read && wait_q) begin
      rd_ok_d = 1'b1;
      case (avs_address)
        rxs_pkg::ADDR_CTRL: rdata_d = 32'(pass_bad_q) << rxs_pkg::CTRL_PASS_BAD_BIT
          | 32'(rx_en_q) << rxs_pkg::CTRL_RX_EN_BIT;
        rxs_pkg::ADDR_STAT: rdata_d = 32'(halted_q) << rxs_pkg::STAT_HALTED_BIT
          | 32'(err_q) << rxs_pkg::STAT_ERR_BIT | 32'(rx_on_q) << rxs_pkg::STAT_RX_ON_BIT;
        rxs_pkg::ADDR_SFIFO: begin
          rd_ok_d = sused != '0;
          rdata_d = rd_ok_d ? smem[srd_q[SFIFO_AW-1:0]] : '0;
        end
        rxs_pkg::ADDR_DFIFO: begin
          rd_ok_d = dused != '0;
          rdata_d = rd_ok_d ? dmem[drd_q[DFIFO_AW-1:0]] : '0;
        end
        rxs_pkg::ADDR_INFO: rdata_d = {8'h00, 8'(sused), 16'(dused)};
        default: rdata_d = '0;
      endcase
    end
    if (accept && avs_read) begin
      if (avs_address == rxs_pkg::ADDR_SFIFO || avs_address == rxs_pkg::ADDR_DFIFO) begin
        if (!rd_ok_q) begin
          err_d = 1'b1;
        end else if (avs_address == rxs_pkg::ADDR_SFIFO) begin
          srd_d = srd_q + 1'b1;
        end else begin
          drd_d = drd_q + 1'b1;
        end
      end
    end
    if (accept && avs_write) begin
      if (avs_address == rxs_pkg::ADDR_CTRL) begin
        if (avs_byteenable[0]) begin
          rx_en_d = avs_writedata[rxs_pkg::CTRL_RX_EN_BIT];
        end
        if (avs_byteenable[2]) begin
          pass_bad_d = avs_writedata[rxs_pkg::CTRL_PASS_BAD_BIT];
        end
      end else if (avs_address == rxs_pkg::ADDR_STAT && avs_byteenable[0]) begin
        // write one to clear; a same-cycle event keeps the flag set
        if (avs_writedata[rxs_pkg::STAT_ERR_BIT] && !(pend_q && !spush)) begin
          err_d = 1'b0;
        end
        if (avs_writedata[rxs_pkg::STAT_HALTED_BIT] && !halt_d) begin
          halted_d = 1'b0;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= rxs_pkg::ST_IDLE;
      {nib_q, half_q, cnt_q, word_q, lane_q, lt_hi_q} <= '0;
      crc_q <= rxs_pkg::CRC_INIT;
      {mcast_q, ftype_q, late_q, wdog_q, mii_q, ovf_q} <= '0;
      {dwr_q, dcommit_q, drd_q, swr_q, srd_q} <= '0;
      {pend_q, sword_q, rx_on_q, halt_q, halted_q} <= '0;
      {rx_en_q, pass_bad_q, err_q, rd_ok_q, rdata_q} <= '0;
      wait_q <= 1'b1;
    end else begin
      state_q <= state_d;
      {nib_q, half_q, cnt_q, word_q, lane_q, lt_hi_q} <= {nib_d, half_d, cnt_d, word_d, lane_d, lt_hi_d};
      crc_q <= crc_d;
      {mcast_q, ftype_q, late_q, wdog_q, mii_q, ovf_q} <= {mcast_d, ftype_d, late_d, wdog_d, mii_d, ovf_d};
      {dwr_q, dcommit_q, drd_q, swr_q, srd_q} <= {dwr_d, dcommit_d, drd_d, swr_d, srd_d};
      {pend_q, sword_q, rx_on_q, halt_q, halted_q} <= {pend_d, sword_d, rx_on_d, halt_d, halted_d};
      {rx_en_q, pass_bad_q, err_q, rd_ok_q, rdata_q} <= {rx_en_d, pass_bad_d, err_d, rd_ok_d, rdata_d};
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign receiver_halted_interrupt = halt_q;
  assign receive_error_flag = err_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_end;
    end_frame && pend_d;
  endsequence

  a_halt_single: assert property (halt_q |=> !halt_q [*2]) else $error("halt pulse too long");
  a_halt_cause: assert property (halt_q |-> !rx_on_q && !$past(rx_en_q)) else $error("halt without stop");
  a_status_rsvd: assert property (spush |-> sword_q[9:8] == 2'b00 && !sword_q[0]) else $error("reserved set");
  a_status_es: assert property (spush |-> sword_q[rxs_pkg::SW_ERR_SUM] == (sword_q[rxs_pkg::SW_RUNT]
    || sword_q[rxs_pkg::SW_LONG] || sword_q[rxs_pkg::SW_LATE] || sword_q[rxs_pkg::SW_CRC]))
    else $error("summary bit wrong");
  a_drib_late: assert property (spush && sword_q[rxs_pkg::SW_LATE] |-> !sword_q[rxs_pkg::SW_DRIB])
    else $error("dribble with late collision");
  a_ftype_short: assert property (spush && sword_q[29:16] < rxs_pkg::HDR_BYTES |-> !sword_q[rxs_pkg::SW_FTYPE])
    else $error("frame type on short frame");
  // an overrun drop raises the flag one cycle after the refused push
  a_status_order: assert property (s_frame_end |=> (pend_q && spush) or (pend_q ##1 err_q))
    else $error("status lost");
  a_runt_pass: assert property (spush && sword_q[rxs_pkg::SW_RUNT] |-> $past(pass_bad_q))
    else $error("runt passed");
  a_underrun_err: assert property (accept && avs_read && avs_address == rxs_pkg::ADDR_DFIFO && !rd_ok_q
    |=> err_q) else $error("underrun not flagged");
  a_err_keeps_rx: assert property (err_q && rx_en_q && !rx_on_q |=> rx_on_q) else $error("error stopped rx");
endmodule

// File: dv/rxs_phy_model.sv
// rxs_phy_model: behavioural mii receive source standing in for the phy
module rxs_phy_model (
  input wire logic clk,
  output logic mii_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_rx_er,
  output logic mii_col
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet lines at time zero
  initial begin
    mii_rx_dv = 1'b0;
    mii_rxd = 4'h0;
    mii_rx_er = 1'b0;
    mii_col = 1'b0;
  end

  // own reflected crc32 step, kept apart from the design's crc logic
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ 32'(d);
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ rxs_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // one nibble per clock, changed just after the edge
  task automatic nib(input logic [3:0] v, input logic er, input logic col);
    @(posedge clk);
    mii_rx_dv <= 1'b1;
    mii_rxd <= v;
    mii_rx_er <= er;
    mii_col <= col;
  endtask

  // n bytes including fcs; er/col strike at byte ev_at; drib appends one odd nibble
  task automatic send(input int n, input logic [7:0] da0, input logic [15:0] lt, input logic er,
                      input logic col, input int ev_at, input logic drib, input logic bad);
    logic [31:0] crc;
    logic [7:0] b;
    crc = 32'hFFFF_FFFF;
    for (int i = 0; i < 7; i++) nib(4'h5, 1'b0, 1'b0);
    nib(4'hD, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      if (i == 0) b = da0;
      else if (i == 12) b = lt[15:8];
      else if (i == 13) b = lt[7:0];
      else b = 8'(i * 7);
      if (i >= n - 4) b = ~crc[8 * (i - n + 4) +: 8] ^ 8'(bad);
      else crc = crc_step(crc, b);
      nib(b[3:0], er && i == ev_at, col && i == ev_at);
      nib(b[7:4], 1'b0, 1'b0);
    end
    if (drib) nib(4'hA, 1'b0, 1'b0);
    // the data lines do not hold their last value once dv drops
    @(posedge clk);
    mii_rx_dv <= 1'b0;
    mii_rxd <= ~mii_rxd;
    mii_rx_er <= 1'b0;
    mii_col <= 1'b0;
  endtask
endmodule

// File: dv/rx_status_and_receiver_control_tb.sv
// rx_status_and_receiver_control_tb: self-checking bench for the receive status block
module rx_status_and_receiver_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, receiver_halted_interrupt, receive_error_flag;
  logic mii_rx_dv, mii_rx_er, mii_col;
  logic [3:0] mii_rxd, avs_byteenable;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int mismatches, compares, halt_pulses;

  // small status fifo so an overrun is cheap; data fifo large enough for a watchdog frame
  rxs_rx_status #(.DFIFO_AW(10), .SFIFO_AW(2)) i_dut (.clk(clk), .rst_n(rst_n), .mii_rx_dv(mii_rx_dv),
    .mii_rxd(mii_rxd), .mii_rx_er(mii_rx_er), .mii_col(mii_col), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .receiver_halted_interrupt(receiver_halted_interrupt), .receive_error_flag(receive_error_flag));
  rxs_phy_model i_phy (.clk(clk), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_rx_er(mii_rx_er),
    .mii_col(mii_col));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // count halted pulses; a stretched pulse counts more than once
  always @(posedge clk) begin
    if (receiver_halted_interrupt === 1'b1) halt_pulses++;
  end

  task automatic end_sim();
    $display("counts: mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) begin
      mismatches++;
      $display("[ERR] %0t bus access never answered", $time);
      end_sim();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdr(input logic [4:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask

  // pop every committed data word
  task automatic drain();
    logic [31:0] n, x;
    rdr(rxs_pkg::ADDR_INFO, n);
    for (int i = 0; i < int'(n[15:0]); i++) rdr(rxs_pkg::ADDR_DFIFO, x);
  endtask

  // send one frame, then judge its status word, its first data word, and drain the rest
  task automatic frame(input int n, input logic [7:0] da0, input logic [15:0] lt, input logic er,
                       input logic col, input logic drib, input logic bad, input logic [31:0] mask);
    logic [31:0] exp, rd;
    exp = 32'(n > 2048 ? 2048 : n) << 16;
    exp[rxs_pkg::SW_RUNT] = n < 64;
    exp[rxs_pkg::SW_MCAST] = da0[0];
    exp[rxs_pkg::SW_LONG] = n > 1518;
    exp[rxs_pkg::SW_LATE] = col;
    exp[rxs_pkg::SW_FTYPE] = n >= 14 && lt > 16'h05DC;
    exp[rxs_pkg::SW_WDOG] = n > 2048;
    exp[rxs_pkg::SW_MIIERR] = er;
    exp[rxs_pkg::SW_DRIB] = drib && !col;
    exp[rxs_pkg::SW_CRC] = er || bad;
    exp[rxs_pkg::SW_ERR_SUM] = exp[11] | exp[7] | exp[6] | exp[1];
    i_phy.send(n, da0, lt, er, col, 70, drib, bad);
    repeat (4) @(posedge clk);
    rdr(rxs_pkg::ADDR_SFIFO, rd);
    chk(rd & mask, exp & mask, "status word");
    rdr(rxs_pkg::ADDR_DFIFO, rd);
    chk(rd, {8'h15, 8'h0E, 8'h07, da0}, "first data word");
    drain();
  endtask

  // fifo underruns and a status overrun raise the flag; reception carries on
  task automatic t_err();
    rdr(rxs_pkg::ADDR_SFIFO, q);
    chk(q, 32'h0000_0000, "empty status read");
    chk(32'(receive_error_flag), 32'h0000_0001, "flag after status underrun");
    wr(rxs_pkg::ADDR_STAT, 32'h0000_0002);
    chk(32'(receive_error_flag), 32'h0000_0000, "flag after clear");
    rdr(rxs_pkg::ADDR_DFIFO, q);
    rdr(rxs_pkg::ADDR_STAT, q);
    chk(q & 32'h0000_0002, 32'h0000_0002, "flag after data underrun");
    wr(rxs_pkg::ADDR_STAT, 32'h0000_0002);
    for (int i = 0; i < 5; i++) i_phy.send(64, 8'h02, 16'h0800, 1'b0, 1'b0, 0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk(32'(receive_error_flag), 32'h0000_0001, "flag after status overrun");
    rdr(rxs_pkg::ADDR_INFO, q);
    chk(q & 32'h00FF_0000, 32'h0004_0000, "status words queued");
    for (int i = 0; i < 4; i++) begin
      rdr(rxs_pkg::ADDR_SFIFO, q);
      chk(q, 32'h0040_0020, "queued status word");
    end
    drain();
    frame(64, 8'h01, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    wr(rxs_pkg::ADDR_STAT, 32'h0000_0002);
  endtask

  // halt the receiver, see one pulse, ignore traffic, then resume
  task automatic t_stop();
    halt_pulses = 0;
    wr(rxs_pkg::ADDR_CTRL, 32'h0001_0000);
    repeat (20) @(posedge clk);
    chk(32'(halt_pulses), 32'h0000_0001, "halted pulses");
    rdr(rxs_pkg::ADDR_STAT, q);
    chk(q & 32'h0000_0005, 32'h0000_0004, "stopped status");
    i_phy.send(64, 8'h01, 16'h0800, 1'b0, 1'b0, 0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rdr(rxs_pkg::ADDR_INFO, q);
    chk(q, 32'h0000_0000, "frame taken while stopped");
    wr(rxs_pkg::ADDR_CTRL, 32'h0001_0004);
    wr(rxs_pkg::ADDR_STAT, 32'h0000_0004);
    rdr(rxs_pkg::ADDR_STAT, q);
    chk(q & 32'h0000_0005, 32'h0000_0001, "receiver on again, halted cleared");
    frame(64, 8'h01, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
  endtask

  // overall guard against a hang
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t run took too long", $time);
    end_sim();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    mismatches = 0;
    compares = 0;
    halt_pulses = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({avs_waitrequest, receiver_halted_interrupt, receive_error_flag}), 32'h0000_0004, "reset outputs");
    rdr(rxs_pkg::ADDR_CTRL, q);
    chk(q, 32'h0000_0000, "control after reset");
    rdr(5'h14, q);
    chk(q, 32'h0000_0000, "unmapped read");
    wr(rxs_pkg::ADDR_CTRL, 32'h0000_0004);
    frame(64, 8'h01, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(100, 8'h02, 16'h05DC, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    i_phy.send(63, 8'h02, 16'h0800, 1'b0, 1'b0, 0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rdr(rxs_pkg::ADDR_INFO, q);
    chk(q, 32'h0000_0000, "runt dropped without pass bad");
    wr(rxs_pkg::ADDR_CTRL, 32'h0001_0004);
    frame(63, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(13, 8'h01, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(1518, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(1519, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(2100, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFD);
    frame(100, 8'h02, 16'h0800, 1'b0, 1'b1, 1'b1, 1'b0, 32'hFFFF_FFFD);
    frame(100, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b1, 1'b0, 32'hFFFF_FFFF);
    frame(100, 8'h02, 16'h0800, 1'b1, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
    frame(100, 8'h01, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b1, 32'hFFFF_FFFF);
    t_err();
    t_stop();
    end_sim();
  end
endmodule
